// ### include/link_mgmt_pkg.sv
// Shared constants for the management confirmation and indication port
package link_mgmt_pkg;

	// Register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h04;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
	localparam logic [7:0] OFS_REQUEST = 8'h0c;
	localparam logic [7:0] OFS_REQ_TIME = 8'h10;
	localparam logic [7:0] OFS_CONFIRM = 8'h14;
	localparam logic [7:0] OFS_DOMAIN_IDENT = 8'h18;
	localparam logic [7:0] OFS_LINK_PARAMS = 8'h1c;
	localparam logic [7:0] OFS_MAX_TIME = 8'h20;
	localparam logic [7:0] OFS_BLOCKED_DEST = 8'h24;
	localparam logic [7:0] OFS_NBR_COUNT = 8'h28;
	localparam logic [7:0] OFS_NBR_INDEX = 8'h2c;
	localparam logic [7:0] OFS_NBR_DATA = 8'h30;
	localparam logic [7:0] OFS_MSG_LEN = 8'h34;
	localparam logic [7:0] OFS_MSG_INDEX = 8'h38;
	localparam logic [7:0] OFS_MSG_DATA = 8'h3c;

	// Status, clear and enable bit positions
	localparam int ST_CONFIRM = 0;
	localparam int ST_DOMAIN = 1;
	localparam int ST_CLASH = 2;
	localparam int ST_NBR = 3;
	localparam int ST_DROP = 4;
	localparam int ST_BLOCK = 5;
	localparam int ST_NORES = 6;
	localparam int ST_PARAM = 7;
	localparam int ST_MSG = 8;
	localparam int N_EVENTS = 9;

	// Request and link parameter field positions
	localparam int FLD_SEC_LSB = 0;
	localparam int FLD_BEACON_LSB = 2;
	localparam int FLD_ACCESS_BIT = 4;
	localparam int FLD_ROBUST_LSB = 5;
	localparam int FLD_END_NODE_BIT = 7;
	localparam int REQ_W = 7;

	// Codes and limits
	localparam logic [1:0] BEACON_RESERVED = 2'h3;
	localparam logic [15:0] TIME_MIN = 16'h001a;
	localparam logic [15:0] TIME_MAX = 16'h14ff;
	localparam logic [15:0] TIME_OFF = 16'hffff;
	localparam int TIME_UNIT_MS = 10;
	localparam logic CONFIRM_OK = 1'b0;
	localparam logic CONFIRM_DENIED = 1'b1;
	localparam int MSG_MAX_BYTES = 992;
	localparam int MSG_MIN_BYTES = 1;
	localparam int NBR_DEPTH_DEF = 8;

	// Reset values
	localparam logic [15:0] RST_REQ_TIME = 16'hffff;
	localparam logic [15:0] RST_MAX_TIME = 16'hffff;
	localparam logic [N_EVENTS-1:0] RST_IRQ_ENABLE = 9'h000;

	// Request sequencer
	typedef enum logic [0:0] {
		REQ_IDLE = 1'b0,
		REQ_CHECK = 1'b1
	} req_state_type;

endpackage

// ### include/msg_store_if.sv
// Port between the indication logic and the message byte store
`timescale 1ns/10ps
`default_nettype none
interface msg_store_if #(
	parameter int IDX_W = 10
);
	logic wr_en;
	logic [IDX_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic [IDX_W-1:0] rd_addr;
	logic [7:0] rd_data;

	modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
	modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface
`default_nettype wire

// ### hdl/mgmt_msg_store.sv
// Byte store for one recovered management message
`timescale 1ns/10ps
`default_nettype none
module mgmt_msg_store #(
	parameter int DEPTH = 992,
	parameter int IDX_W = 10
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Store port
	msg_store_if.store port_if
);

	logic [7:0] mem_q [DEPTH];
	logic [7:0] mem_d [DEPTH];

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_d[i] = mem_q[i];
		end
		if (port_if.wr_en && (int'(port_if.wr_addr) < DEPTH)) begin
			mem_d[port_if.wr_addr] = port_if.wr_data;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= 8'h00;
			end
		end else begin
			mem_q <= mem_d;
		end
	end

	assign port_if.rd_data = (int'(port_if.rd_addr) < DEPTH) ? mem_q[port_if.rd_addr] : 8'h00;

endmodule
`default_nettype wire

// ### hdl/link_mgmt_indication_port.sv
// Management confirmation and indication port toward the upper layer
// Function
// R01 - Confirm status 1 when any requested setting cannot be honoured, else 0.
// R02 - Report the 16-bit domain identifier chosen in self-configuration.
// R03 - Raise a flag when another domain uses the same identifier.
// R04 - Report the discovered neighbour domain identifiers, 16 bits each.
// R05 - Raise a flag when an outgoing frame is dropped for error or timeout.
// R06 - Raise a flag with the 16-bit destination that may not be sent to.
// R07 - Raise a flag when the node runs out of frame resources.
// R08 - End-nodes report domain security level as a 2-bit code.
// R09 - End-nodes report domain beacon mode as a 2-bit code.
// R10 - End-nodes report max frame transmit time in 10 ms units, FFFF disables.
// R11 - Report medium access mode, 1 centralized, 0 distributed; master only.
// R12 - End-nodes report transmission robustness as a 2-bit code.
// R13 - Pass up each recovered management message of 1 to 992 bytes.
// R14 - The upper layer issues the parameter request that the confirm answers.
// R15 - Each indication flag stays set until the upper layer clears it.
`timescale 1ns/10ps
`default_nettype none
module link_mgmt_indication_port import link_mgmt_pkg::*; #(
	parameter int NBR_DEPTH = NBR_DEPTH_DEF,
	parameter int MSG_DEPTH = MSG_MAX_BYTES
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Register bus
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	// Interrupt
	output logic irq_out,
	// Settings toward link and physical management
	input wire logic apply_refuse_in,
	output logic apply_pulse_out,
	output logic [1:0] apply_security_out,
	output logic [1:0] apply_beacon_out,
	output logic [15:0] apply_time_out,
	output logic apply_access_out,
	output logic [1:0] apply_robust_out,
	output logic mgmt_confirm_out,
	// Indications from link management
	input wire logic end_node_in,
	input wire logic [15:0] selected_domain_ident_in,
	input wire logic selected_domain_valid_in,
	input wire logic domain_ident_clash_in,
	input wire logic [15:0] neighbour_domain_in,
	input wire logic neighbour_domain_valid_in,
	input wire logic tx_frame_dropped_in,
	input wire logic tx_dest_blocked_in,
	input wire logic [15:0] blocked_dest_in,
	input wire logic node_out_of_resources_in,
	input wire logic params_valid_in,
	input wire logic [1:0] domain_security_code_in,
	input wire logic [1:0] beacon_mode_code_in,
	input wire logic [15:0] max_frame_tx_time_in,
	input wire logic access_mode_select_in,
	input wire logic [1:0] robustness_mode_code_in,
	// Recovered management data unit bytes
	input wire logic [7:0] mgmt_data_unit_byte_in,
	input wire logic mgmt_data_unit_valid_in,
	input wire logic mgmt_data_unit_last_in
);

	localparam int NBR_CNT_W = $clog2(NBR_DEPTH + 1);
	localparam int NBR_IDX_W = $clog2(NBR_DEPTH);
	localparam int MSG_IDX_W = $clog2(MSG_DEPTH + 1);

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
		return addr == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Request and confirmation

	req_state_type req_state_q, req_state_d;
	logic [REQ_W-1:0] req_word_q, req_word_d;
	logic [15:0] req_time_q, req_time_d;
	logic confirm_q, confirm_d;
	logic apply_pulse_q, apply_pulse_d;
	logic [REQ_W-1:0] apply_word_q, apply_word_d;
	logic [15:0] apply_time_q, apply_time_d;
	logic req_time_ok;
	logic req_deny;

	assign req_time_ok = ((req_time_q >= TIME_MIN) && (req_time_q <= TIME_MAX))
		|| (req_time_q == TIME_OFF);
	assign req_deny = apply_refuse_in || end_node_in || !req_time_ok
		|| (req_word_q[FLD_BEACON_LSB +: 2] == BEACON_RESERVED);

	always_comb begin
		req_state_d = req_state_q;
		req_word_d = req_word_q;
		req_time_d = req_time_q;
		confirm_d = confirm_q;
		apply_pulse_d = 1'b0;
		apply_word_d = apply_word_q;
		apply_time_d = apply_time_q;
		if (reg_wr_in && reg_hit(reg_addr_in, OFS_REQ_TIME)) begin
			req_time_d = reg_wdata_in[15:0];
		end
		case (req_state_q)
			REQ_IDLE: begin
				if (reg_wr_in && reg_hit(reg_addr_in, OFS_REQUEST)) begin // see R14
					req_word_d = reg_wdata_in[REQ_W-1:0];
					req_state_d = REQ_CHECK;
				end
			end
			REQ_CHECK: begin
				confirm_d = req_deny ? CONFIRM_DENIED : CONFIRM_OK; // see R01
				if (!req_deny) begin
					apply_pulse_d = 1'b1;
					apply_word_d = req_word_q;
					apply_time_d = req_time_q;
				end
				req_state_d = REQ_IDLE;
				if (reg_wr_in && reg_hit(reg_addr_in, OFS_REQUEST)) begin
					req_word_d = reg_wdata_in[REQ_W-1:0];
					req_state_d = REQ_CHECK;
				end
			end
			default: req_state_d = REQ_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			req_state_q <= REQ_IDLE;
			req_word_q <= '0;
			req_time_q <= RST_REQ_TIME;
			confirm_q <= CONFIRM_OK;
			apply_pulse_q <= 1'b0;
			apply_word_q <= '0;
			apply_time_q <= RST_REQ_TIME;
		end else begin
			req_state_q <= req_state_d;
			req_word_q <= req_word_d;
			req_time_q <= req_time_d;
			confirm_q <= confirm_d;
			apply_pulse_q <= apply_pulse_d;
			apply_word_q <= apply_word_d;
			apply_time_q <= apply_time_d;
		end
	end

	assign apply_pulse_out = apply_pulse_q;
	assign apply_security_out = apply_word_q[FLD_SEC_LSB +: 2];
	assign apply_beacon_out = apply_word_q[FLD_BEACON_LSB +: 2];
	assign apply_access_out = apply_word_q[FLD_ACCESS_BIT];
	assign apply_robust_out = apply_word_q[FLD_ROBUST_LSB +: 2];
	assign apply_time_out = apply_time_q;
	assign mgmt_confirm_out = confirm_q;

	////////////////////////////////////////////////////////////////////////////////
	// Sticky status, enable and interrupt

	logic [N_EVENTS-1:0] status_q, status_d;
	logic [N_EVENTS-1:0] enable_q, enable_d;
	logic [N_EVENTS-1:0] events;
	logic [N_EVENTS-1:0] clears;

	always_comb begin
		events = '0;
		events[ST_CONFIRM] = (req_state_q == REQ_CHECK);
		events[ST_DOMAIN] = selected_domain_valid_in;
		events[ST_CLASH] = domain_ident_clash_in; // see R03
		events[ST_NBR] = neighbour_domain_valid_in;
		events[ST_DROP] = tx_frame_dropped_in; // see R05
		events[ST_BLOCK] = tx_dest_blocked_in;
		events[ST_NORES] = node_out_of_resources_in; // see R07
		events[ST_PARAM] = params_valid_in;
		events[ST_MSG] = mgmt_data_unit_valid_in && mgmt_data_unit_last_in;
		clears = (reg_wr_in && reg_hit(reg_addr_in, OFS_IRQ_CLEAR)) ? reg_wdata_in[N_EVENTS-1:0] : '0;
		status_d = (status_q & ~clears) | events; // see R15
		enable_d = enable_q;
		if (reg_wr_in && reg_hit(reg_addr_in, OFS_IRQ_ENABLE)) begin
			enable_d = reg_wdata_in[N_EVENTS-1:0];
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_q <= '0;
			enable_q <= RST_IRQ_ENABLE;
		end else begin
			status_q <= status_d;
			enable_q <= enable_d;
		end
	end

	assign irq_out = |(status_q & enable_q);

	////////////////////////////////////////////////////////////////////////////////
	// Domain identity, blocked destination and link parameters

	logic [15:0] domain_q, domain_d;
	logic [15:0] blocked_q, blocked_d;
	logic [REQ_W-1:0] params_q, params_d;
	logic [15:0] max_time_q, max_time_d;

	always_comb begin
		domain_d = selected_domain_valid_in ? selected_domain_ident_in : domain_q; // see R02
		blocked_d = tx_dest_blocked_in ? blocked_dest_in : blocked_q; // see R06
		params_d = params_q;
		max_time_d = max_time_q;
		if (params_valid_in) begin
			params_d = {robustness_mode_code_in, access_mode_select_in,
				beacon_mode_code_in, domain_security_code_in};
			max_time_d = max_frame_tx_time_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			domain_q <= '0;
			blocked_q <= '0;
			params_q <= '0;
			max_time_q <= RST_MAX_TIME;
		end else begin
			domain_q <= domain_d;
			blocked_q <= blocked_d;
			params_q <= params_d;
			max_time_q <= max_time_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Neighbour domain list

	logic [15:0] nbr_q [NBR_DEPTH];
	logic [15:0] nbr_d [NBR_DEPTH];
	logic [NBR_CNT_W-1:0] nbr_cnt_q, nbr_cnt_d;
	logic [NBR_IDX_W-1:0] nbr_sel_q, nbr_sel_d;
	logic nbr_clear;
	logic nbr_push;
	logic [NBR_CNT_W-1:0] nbr_slot;

	assign nbr_clear = reg_wr_in && reg_hit(reg_addr_in, OFS_NBR_COUNT);
	assign nbr_slot = nbr_clear ? '0 : nbr_cnt_q;
	assign nbr_push = neighbour_domain_valid_in && (int'(nbr_slot) < NBR_DEPTH);

	generate
		for (genvar g = 0; g < NBR_DEPTH; g++) begin : g_nbr
			assign nbr_d[g] = (nbr_push && (nbr_slot == NBR_CNT_W'(g))) ?
				neighbour_domain_in : nbr_q[g]; // see R04
		end
	endgenerate

	always_comb begin
		nbr_cnt_d = nbr_push ? nbr_slot + NBR_CNT_W'(1) : nbr_slot;
		nbr_sel_d = nbr_sel_q;
		if (reg_wr_in && reg_hit(reg_addr_in, OFS_NBR_INDEX)) begin
			nbr_sel_d = reg_wdata_in[NBR_IDX_W-1:0];
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < NBR_DEPTH; i++) begin
				nbr_q[i] <= '0;
			end
			nbr_cnt_q <= '0;
			nbr_sel_q <= '0;
		end else begin
			nbr_q <= nbr_d;
			nbr_cnt_q <= nbr_cnt_d;
			nbr_sel_q <= nbr_sel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Recovered management message

	msg_store_if #(.IDX_W(MSG_IDX_W)) store_if ();

	logic [MSG_IDX_W-1:0] msg_wr_q, msg_wr_d;
	logic [MSG_IDX_W-1:0] msg_len_q, msg_len_d;
	logic [MSG_IDX_W-1:0] msg_rd_q, msg_rd_d;
	logic msg_accept;

	assign msg_accept = mgmt_data_unit_valid_in && (msg_wr_q != MSG_IDX_W'(MSG_DEPTH));

	always_comb begin
		msg_wr_d = msg_wr_q;
		msg_len_d = msg_len_q;
		msg_rd_d = msg_rd_q;
		if (mgmt_data_unit_valid_in) begin
			if (mgmt_data_unit_last_in) begin
				msg_wr_d = '0;
				msg_len_d = msg_accept ? msg_wr_q + MSG_IDX_W'(1) : msg_wr_q; // see R13
			end else if (msg_accept) begin
				msg_wr_d = msg_wr_q + MSG_IDX_W'(1);
			end
		end
		if (reg_wr_in && reg_hit(reg_addr_in, OFS_MSG_INDEX)) begin
			msg_rd_d = reg_wdata_in[MSG_IDX_W-1:0];
		end else if (reg_rd_in && reg_hit(reg_addr_in, OFS_MSG_DATA)) begin
			msg_rd_d = msg_rd_q + MSG_IDX_W'(1);
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			msg_wr_q <= '0;
			msg_len_q <= '0;
			msg_rd_q <= '0;
		end else begin
			msg_wr_q <= msg_wr_d;
			msg_len_q <= msg_len_d;
			msg_rd_q <= msg_rd_d;
		end
	end

	assign store_if.wr_en = msg_accept;
	assign store_if.wr_addr = msg_wr_q;
	assign store_if.wr_data = mgmt_data_unit_byte_in;
	assign store_if.rd_addr = msg_rd_q;

	mgmt_msg_store #(.DEPTH(MSG_DEPTH), .IDX_W(MSG_IDX_W)) u_store (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.port_if(store_if.store)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read data

	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		case (reg_addr_in)
			OFS_STATUS: rd_mux[N_EVENTS-1:0] = status_q;
			OFS_IRQ_ENABLE: rd_mux[N_EVENTS-1:0] = enable_q;
			OFS_REQUEST: rd_mux[REQ_W-1:0] = req_word_q;
			OFS_REQ_TIME: rd_mux[15:0] = req_time_q;
			OFS_CONFIRM: rd_mux[0] = confirm_q;
			OFS_DOMAIN_IDENT: rd_mux[15:0] = domain_q;
			OFS_LINK_PARAMS: begin
				if (end_node_in) begin
					rd_mux[FLD_SEC_LSB +: 2] = params_q[FLD_SEC_LSB +: 2]; // see R08
					rd_mux[FLD_BEACON_LSB +: 2] = params_q[FLD_BEACON_LSB +: 2]; // see R09
					rd_mux[FLD_ROBUST_LSB +: 2] = params_q[FLD_ROBUST_LSB +: 2]; // see R12
				end else begin
					rd_mux[FLD_ACCESS_BIT] = params_q[FLD_ACCESS_BIT]; // see R11
				end
				rd_mux[FLD_END_NODE_BIT] = end_node_in;
			end
			OFS_MAX_TIME: rd_mux[15:0] = end_node_in ? max_time_q : 16'h0000; // see R10
			OFS_BLOCKED_DEST: rd_mux[15:0] = blocked_q;
			OFS_NBR_COUNT: rd_mux[NBR_CNT_W-1:0] = nbr_cnt_q;
			OFS_NBR_INDEX: rd_mux[NBR_IDX_W-1:0] = nbr_sel_q;
			OFS_NBR_DATA: rd_mux[15:0] = nbr_q[nbr_sel_q];
			OFS_MSG_LEN: rd_mux[MSG_IDX_W-1:0] = msg_len_q;
			OFS_MSG_INDEX: rd_mux[MSG_IDX_W-1:0] = msg_rd_q;
			OFS_MSG_DATA: rd_mux[7:0] = store_if.rd_data;
			default: rd_mux = '0;
		endcase
		rdata_d = reg_rd_in ? rd_mux : '0;
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_out = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	a_confirm_denied: assert property ((req_state_q == REQ_CHECK) && req_deny |=> // see R01
		(confirm_q == CONFIRM_DENIED) && !apply_pulse_out && status_q[ST_CONFIRM])
		else $error("denied request not confirmed as 1");
	a_confirm_success: assert property ((req_state_q == REQ_CHECK) && !req_deny |=> // see R01
		(confirm_q == CONFIRM_OK) && apply_pulse_out
		##1 (!apply_pulse_out || ($past(req_state_q) == REQ_CHECK)))
		else $error("accepted request not confirmed as 0");
	a_domain_ident_kept: assert property (selected_domain_valid_in |=> // see R02
		(domain_q == $past(selected_domain_ident_in)) && status_q[ST_DOMAIN])
		else $error("selected domain identifier not captured");
	a_clash_flag_set: assert property (domain_ident_clash_in |=> status_q[ST_CLASH]) // see R03
		else $error("clash flag not raised");
	a_nbr_list_grow: assert property (neighbour_domain_valid_in && !nbr_clear // see R04
		&& (int'(nbr_cnt_q) < NBR_DEPTH) |=> nbr_cnt_q == $past(nbr_cnt_q) + NBR_CNT_W'(1))
		else $error("neighbour list did not grow");
	a_drop_irq_rise: assert property (tx_frame_dropped_in && enable_q[ST_DROP] // see R05
		&& !(reg_wr_in && reg_hit(reg_addr_in, OFS_IRQ_ENABLE)) |=> irq_out)
		else $error("dropped frame did not interrupt");
	a_blocked_dest_kept: assert property (tx_dest_blocked_in |=> // see R06
		(blocked_q == $past(blocked_dest_in)) && status_q[ST_BLOCK])
		else $error("blocked destination not captured");
	a_nores_flag_set: assert property (node_out_of_resources_in |=> status_q[ST_NORES]) // see R07
		else $error("resource flag not raised");
	a_params_master_hidden: assert property (reg_rd_in // see R08
		&& reg_hit(reg_addr_in, OFS_LINK_PARAMS)
		&& !end_node_in |=> (reg_rdata_out[3:0] == 4'h0) && (reg_rdata_out[6:5] == 2'h0))
		else $error("end-node fields visible on master");
	a_time_master_hidden: assert property (reg_rd_in && reg_hit(reg_addr_in, OFS_MAX_TIME) // see R10
		&& !end_node_in |=> reg_rdata_out == '0)
		else $error("max time visible on master");
	a_access_end_hidden: assert property (reg_rd_in && reg_hit(reg_addr_in, OFS_LINK_PARAMS) // see R11
		&& end_node_in |=> !reg_rdata_out[FLD_ACCESS_BIT] && reg_rdata_out[FLD_END_NODE_BIT])
		else $error("access mode visible on end-node");
	a_msg_len_range: assert property (mgmt_data_unit_valid_in && mgmt_data_unit_last_in |=> // see R13
		(int'(msg_len_q) >= MSG_MIN_BYTES) && (int'(msg_len_q) <= MSG_DEPTH) && status_q[ST_MSG])
		else $error("message length out of range");
	a_sticky_hold: assert property (status_q[ST_CLASH] && !(reg_wr_in // see R15
		&& reg_hit(reg_addr_in, OFS_IRQ_CLEAR) && reg_wdata_in[ST_CLASH]) |=> status_q[ST_CLASH])
		else $error("clash flag lost without clear");
	a_rdata_only_once: assert property (!reg_rd_in |=> reg_rdata_out == '0)
		else $error("read data outside its cycle");

	c_request_denied: cover property ((req_state_q == REQ_CHECK) && req_deny);
	c_request_applied: cover property (apply_pulse_out);
	c_message_received: cover property (mgmt_data_unit_valid_in && mgmt_data_unit_last_in);
	c_irq_raised: cover property ($rose(irq_out));

endmodule
`default_nettype wire

// ### tb/link_side_model.sv
// Model of link management driving events, levels and message bytes
`timescale 1ns/10ps
`default_nettype none
module link_side_model (
	// Clock
	input wire logic core_clk_in,
	// Levels
	output logic apply_refuse_out,
	output logic end_node_out,
	// Event strobes and their value
	output logic [7:0] event_out,
	output logic [15:0] value_out,
	// Message bytes
	output logic [7:0] byte_out,
	output logic byte_valid_out,
	output logic byte_last_out
);
	initial begin
		apply_refuse_out = 1'b0;
		end_node_out = 1'b0;
		event_out = 8'h00;
		value_out = 16'h0000;
		byte_out = 8'h00;
		byte_valid_out = 1'b0;
		byte_last_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic set_levels(input logic r, input logic e);
		@(posedge core_clk_in);
		apply_refuse_out <= r;
		end_node_out <= e;
	endtask
	// One-cycle strobe, value scrambled once released
	task automatic pulse(input int idx, input logic [15:0] v);
		@(posedge core_clk_in);
		event_out <= 8'h01 << idx;
		value_out <= v;
		@(posedge core_clk_in);
		event_out <= 8'h00;
		value_out <= ~v;
	endtask
	task automatic send_msg(input int n, input logic [7:0] first);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk_in);
			byte_valid_out <= 1'b1;
			byte_last_out <= (i == n - 1);
			byte_out <= first + 8'(i);
		end
		@(posedge core_clk_in);
		byte_valid_out <= 1'b0;
		byte_last_out <= 1'b0;
		byte_out <= ~byte_out;
	endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the management indication port
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import link_mgmt_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	wire logic [31:0] reg_rdata;
	wire logic irq, refuse, end_node, byte_valid, byte_last, pulse, conf, access;
	wire logic [7:0] ev, bt;
	wire logic [15:0] val, apply_time;
	wire logic [1:0] sec, bcn, rob;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	always #25 core_clk = ~core_clk;
	link_side_model i_link_side_model (.core_clk_in(core_clk), .apply_refuse_out(refuse),
		.end_node_out(end_node), .event_out(ev), .value_out(val), .byte_out(bt),
		.byte_valid_out(byte_valid), .byte_last_out(byte_last));
	link_mgmt_indication_port i_link_mgmt_indication_port (.core_clk_in(core_clk),
		.resetn_in(resetn), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq), .apply_refuse_in(refuse),
		.apply_pulse_out(pulse), .apply_security_out(sec), .apply_beacon_out(bcn),
		.apply_time_out(apply_time), .apply_access_out(access), .apply_robust_out(rob),
		.mgmt_confirm_out(conf), .end_node_in(end_node), .selected_domain_ident_in(val),
		.selected_domain_valid_in(ev[1]), .domain_ident_clash_in(ev[2]),
		.neighbour_domain_in(val), .neighbour_domain_valid_in(ev[3]),
		.tx_frame_dropped_in(ev[4]), .tx_dest_blocked_in(ev[5]), .blocked_dest_in(val),
		.node_out_of_resources_in(ev[6]), .params_valid_in(ev[7]),
		.domain_security_code_in(val[1:0]), .beacon_mode_code_in(val[3:2]),
		.max_frame_tx_time_in(val), .access_mode_select_in(val[4]),
		.robustness_mode_code_in(val[6:5]), .mgmt_data_unit_byte_in(bt),
		.mgmt_data_unit_valid_in(byte_valid), .mgmt_data_unit_last_in(byte_last));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, e);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		check({irq, pulse, conf, apply_time}, {3'h0, 16'hffff});
		rdc(OFS_REQ_TIME, 32'hffff);
		rdc(OFS_IRQ_ENABLE, 32'h0);
		rdc(OFS_CONFIRM, 32'h0);
		wr(OFS_DOMAIN_IDENT, 32'hffff);
		rdc(OFS_DOMAIN_IDENT, 32'h0);
		rdc(8'h40, 32'h0);
	endtask
	task automatic test_request();
		logic [15:0] tt [8] = '{16'h001a, 16'h14ff, 16'hffff, 16'h0019, 16'h1500,
			16'h0100, 16'h0100, 16'h0100};
		logic [6:0] rq [8] = '{7'h21, 7'h5a, 7'h13, 7'h00, 7'h00, 7'h0c, 7'h7b, 7'h00};
		logic deny;
		for (int i = 0; i < 8; i++) begin
			deny = (i >= 6) || (rq[i][3:2] == 2'h3);
			deny = deny || !((tt[i] >= 16'h001a && tt[i] <= 16'h14ff) || tt[i] == 16'hffff);
			i_link_side_model.set_levels(i == 6, i == 7);
			wr(OFS_REQ_TIME, 32'(tt[i]));
			wr(OFS_REQUEST, 32'(rq[i]));
			@(posedge core_clk);
			#1 check(32'(conf), 32'(deny));
			check(32'(pulse), 32'(!deny));
			if (!deny) check({apply_time, 9'h0, rob, access, bcn, sec}, {tt[i], 9'h0, rq[i]});
			@(posedge core_clk);
			#1 check(32'(pulse), 32'h0);
			rdc(OFS_STATUS, 32'h1);
			wr(OFS_IRQ_CLEAR, 32'h1);
		end
		i_link_side_model.set_levels(1'b0, 1'b0);
	endtask
	task automatic test_events();
		logic [15:0] nb [3] = '{16'h1233, 16'h4444, 16'h5555};
		wr(OFS_NBR_COUNT, 32'h0);
		wr(OFS_IRQ_ENABLE, 32'h1ff);
		for (int i = 1; i < 7; i++) begin
			i_link_side_model.pulse(i, 16'h1230 + 16'(i));
			@(posedge core_clk);
			#1 check(32'(irq), 32'h1);
			rdc(OFS_STATUS, 32'h1 << i);
			if (i == 1) rdc(OFS_DOMAIN_IDENT, 32'h1231);
			if (i == 5) rdc(OFS_BLOCKED_DEST, 32'h1235);
			wr(OFS_IRQ_CLEAR, 32'h1 << i);
			#1 check(32'(irq), 32'h0);
		end
		for (int j = 1; j < 3; j++) i_link_side_model.pulse(3, nb[j]);
		rdc(OFS_NBR_COUNT, 32'h3);
		for (int j = 0; j < 3; j++) begin
			wr(OFS_NBR_INDEX, 32'(j));
			rdc(OFS_NBR_DATA, 32'(nb[j]));
		end
		wr(OFS_IRQ_CLEAR, 32'h8);
		wr(OFS_IRQ_ENABLE, 32'h1ef);
		i_link_side_model.pulse(4, 16'h0);
		@(posedge core_clk);
		#1 check(32'(irq), 32'h0);
		rdc(OFS_STATUS, 32'h10);
		wr(OFS_IRQ_CLEAR, 32'h10);
	endtask
	task automatic test_params();
		i_link_side_model.set_levels(1'b0, 1'b1);
		i_link_side_model.pulse(7, 16'h0d75);
		rdc(OFS_LINK_PARAMS, 32'he5);
		rdc(OFS_MAX_TIME, 32'h0d75);
		i_link_side_model.set_levels(1'b0, 1'b0);
		rdc(OFS_LINK_PARAMS, 32'h10);
		rdc(OFS_MAX_TIME, 32'h0);
		wr(OFS_IRQ_CLEAR, 32'h80);
	endtask
	task automatic test_msg();
		i_link_side_model.send_msg(3, 8'ha0);
		rdc(OFS_MSG_LEN, 32'h3);
		rdc(OFS_STATUS, 32'h100);
		wr(OFS_MSG_INDEX, 32'h0);
		for (int j = 0; j < 3; j++) rdc(OFS_MSG_DATA, 32'ha0 + 32'(j));
		i_link_side_model.send_msg(993, 8'h00);
		rdc(OFS_MSG_LEN, 32'h3e0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		test_reset();
		test_request();
		test_events();
		test_params();
		test_msg();
		end_of_test();
	end
endmodule
`default_nettype wire
